// ==== hw/pbl_pkg.sv ====
package pbl_pkg;

  // ==========================================================
  // Widths
  localparam int PIX_W = 14;
  localparam int GAIN_W = 8;
  localparam int ADDR_W = 7;
  localparam int WIDE_W = 26;
  localparam int GAIN_FRAC = 4;
  localparam logic [PIX_W-1:0] PIX_MAX = 14'h3FFF;

  // ==========================================================
  // Banks and byte addresses (14/16-bit fields: low byte first)
  localparam logic BANK0 = 1'b0;
  localparam logic BANK1 = 1'b1;
  localparam logic [ADDR_W-1:0] ADDR_SENSOR_TYPE = 7'h04;
  localparam logic [ADDR_W-1:0] ADDR_FINE_OFF_LO = 7'h26;
  localparam logic [ADDR_W-1:0] ADDR_FINE_OFF_HI = 7'h27;
  localparam logic [ADDR_W-1:0] ADDR_CLAMP_DIS = 7'h2A;
  localparam logic [ADDR_W-1:0] ADDR_FIXED_LO = 7'h2B;
  localparam logic [ADDR_W-1:0] ADDR_FIXED_HI = 7'h2C;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_EE = 7'h48;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_EO = 7'h49;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_OE = 7'h4A;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_OO = 7'h4B;
  localparam logic [ADDR_W-1:0] ADDR_TARGET_LO = 7'h4C;
  localparam logic [ADDR_W-1:0] ADDR_TARGET_HI = 7'h4D;
  localparam logic [ADDR_W-1:0] ADDR_ANA_GAIN = 7'h4E;

  // ==========================================================
  // Reset values
  localparam logic RST_SENSOR_TYPE = 1'b0;
  localparam logic [15:0] RST_FINE_OFF = 16'h0000;
  localparam logic RST_CLAMP_DIS = 1'b0;
  localparam logic [PIX_W-1:0] RST_FIXED = 14'h0000;
  localparam logic [GAIN_W-1:0] RST_GAIN = 8'h0F;
  localparam logic [PIX_W-1:0] RST_TARGET = 14'h0080;
  localparam logic [GAIN_W-1:0] RST_ANA_GAIN = 8'h00;

  // ==========================================================
  // Row phase
  typedef enum logic {PBL_PH_DARK, PBL_PH_ACTIVE} pbl_phase_e;

endpackage

// ==== hw/pbl_black_gain.sv ====
// Summary of operation
// - Each output pixel is ADC sample minus ADC black level plus target level, clipped.
// - The target black level comes from a 14-bit configuration field.
// - With clamp disable at 0 the ADC black level is derived per row from shielded pixels.
// - With clamp disable at 1 the fixed programmed ADC black level is used for all rows.
// - The fixed ADC black level is held in a 14-bit configuration field.
// - Four phase gains, by row and column parity, each have an 8-bit setting.
// - Each phase gain factor is its setting plus one, divided by sixteen.
// - Digital gain spans one sixteenth at setting 0 up to about sixteen times.
// - Digital gain is applied after black level correction.
`timescale 1ns/1ns
module pbl_black_gain #(
  parameter int DARK_LOG2 = 3
) (
  input wire logic core_clk, // Pixel clock, 125 MHz
  input wire logic arst_n, // Async reset, active low
  input wire logic cfg_wr, // Register write strobe
  input wire logic cfg_rd, // Register read strobe
  input wire logic cfg_bank, // Register bank
  input wire logic [pbl_pkg::ADDR_W-1:0] cfg_addr, // Register address
  input wire logic [7:0] cfg_wdata, // Write byte
  output logic [7:0] cfg_rdata, // Read byte, one cycle after cfg_rd
  input wire logic in_valid, // ADC sample valid
  output logic in_ready, // Stage can take a sample
  input wire logic [pbl_pkg::PIX_W-1:0] in_data, // ADC sample
  input wire logic in_sof, // First sample of frame
  input wire logic in_sol, // First sample of row
  input wire logic in_dark, // Sample is a shielded dark pixel
  output logic out_valid, // Output pixel valid
  input wire logic out_ready, // Serializer takes pixel
  output logic [pbl_pkg::PIX_W-1:0] out_data, // Corrected pixel
  output logic sensor_type, // 1 colour, 0 mono
  output logic [pbl_pkg::GAIN_W-1:0] analog_gain_setting, // To column amp
  output logic [15:0] fine_black_offset // To analog offset DAC
);

  // ==========================================================
  // Elaboration check
  generate
    if (DARK_LOG2 < 0 || DARK_LOG2 > 4) begin : g_bad_log2
      $error("DARK_LOG2 must lie in 0..4");
    end
    // Product of a full pixel and the top gain must not wrap
    if (pbl_pkg::WIDE_W < pbl_pkg::PIX_W + pbl_pkg::GAIN_W + 2) begin : g_wide
      $error("WIDE_W too narrow for the gain product");
    end
  endgenerate

  localparam logic [4:0] DARK_N = 5'(1 << DARK_LOG2);

  // ==========================================================
  // State
  typedef struct packed {
    logic sensor_type;
    logic [15:0] fine_off;
    logic clamp_dis;
    logic [pbl_pkg::PIX_W-1:0] fixed_blk;
    logic [3:0][pbl_pkg::GAIN_W-1:0] gain;
    logic [pbl_pkg::PIX_W-1:0] target;
    logic [pbl_pkg::GAIN_W-1:0] ana_gain;
    pbl_pkg::pbl_phase_e phase;
    logic row_odd;
    logic col_odd;
    logic [pbl_pkg::PIX_W+3:0] dark_sum;
    logic [4:0] dark_cnt;
    logic [pbl_pkg::PIX_W-1:0] row_black;
    logic [1:0][pbl_pkg::PIX_W-1:0] buf_q;
    logic [1:0] cnt;
    logic out_valid;
    logic in_ready;
    logic [7:0] rdata;
  } pbl_state_s;

  pbl_state_s s_r;
  pbl_state_s s_nxt;

  // ==========================================================
  // Register fields; one decode serves reads and writes alike
  typedef enum {
    PBL_F_NONE,
    PBL_F_TYPE,
    PBL_F_GAIN_EE,
    PBL_F_GAIN_EO,
    PBL_F_GAIN_OE,
    PBL_F_GAIN_OO,
    PBL_F_TGT_LO,
    PBL_F_TGT_HI,
    PBL_F_ANA,
    PBL_F_FINE_LO,
    PBL_F_FINE_HI,
    PBL_F_CLAMP,
    PBL_F_FIX_LO,
    PBL_F_FIX_HI
  } pbl_field_e;

  // ==========================================================
  // Functions
  // Saturate a signed wide value into the pixel range
  function automatic logic [pbl_pkg::PIX_W-1:0] clip_pix(
    input logic signed [pbl_pkg::WIDE_W-1:0] v
  );
    logic [pbl_pkg::PIX_W-1:0] r;
    r = v[pbl_pkg::PIX_W-1:0];
    if (v < 0) begin
      r = '0;
    end else if (v > $signed(pbl_pkg::WIDE_W'(pbl_pkg::PIX_MAX))) begin
      r = pbl_pkg::PIX_MAX;
    end
    return r;
  endfunction

  // Bank and address to field; shared so reads and writes cannot disagree
  function automatic pbl_field_e field_sel(
    input logic bank,
    input logic [pbl_pkg::ADDR_W-1:0] addr
  );
    pbl_field_e f;
    f = PBL_F_NONE;
    if (bank == pbl_pkg::BANK0) begin
      case (addr)
        pbl_pkg::ADDR_SENSOR_TYPE: f = PBL_F_TYPE;
        pbl_pkg::ADDR_GAIN_EE: f = PBL_F_GAIN_EE;
        pbl_pkg::ADDR_GAIN_EO: f = PBL_F_GAIN_EO;
        pbl_pkg::ADDR_GAIN_OE: f = PBL_F_GAIN_OE;
        pbl_pkg::ADDR_GAIN_OO: f = PBL_F_GAIN_OO;
        pbl_pkg::ADDR_TARGET_LO: f = PBL_F_TGT_LO;
        pbl_pkg::ADDR_TARGET_HI: f = PBL_F_TGT_HI;
        pbl_pkg::ADDR_ANA_GAIN: f = PBL_F_ANA;
        default: f = PBL_F_NONE;
      endcase
    end else begin
      case (addr)
        pbl_pkg::ADDR_FINE_OFF_LO: f = PBL_F_FINE_LO;
        pbl_pkg::ADDR_FINE_OFF_HI: f = PBL_F_FINE_HI;
        pbl_pkg::ADDR_CLAMP_DIS: f = PBL_F_CLAMP;
        pbl_pkg::ADDR_FIXED_LO: f = PBL_F_FIX_LO;
        pbl_pkg::ADDR_FIXED_HI: f = PBL_F_FIX_HI;
        default: f = PBL_F_NONE;
      endcase
    end
    return f;
  endfunction

  // Read byte of one field; reserved bits of narrow fields read zero
  function automatic logic [7:0] reg_read(
    input pbl_field_e f,
    input pbl_state_s s
  );
    logic [7:0] d;
    d = 8'h00;
    case (f)
      PBL_F_TYPE: d = {7'h00, s.sensor_type};
      PBL_F_GAIN_EE: d = s.gain[0];
      PBL_F_GAIN_EO: d = s.gain[1];
      PBL_F_GAIN_OE: d = s.gain[2];
      PBL_F_GAIN_OO: d = s.gain[3];
      PBL_F_TGT_LO: d = s.target[7:0];
      PBL_F_TGT_HI: d = {2'b00, s.target[13:8]};
      PBL_F_ANA: d = s.ana_gain;
      PBL_F_FINE_LO: d = s.fine_off[7:0];
      PBL_F_FINE_HI: d = s.fine_off[15:8];
      PBL_F_CLAMP: d = {7'h00, s.clamp_dis};
      PBL_F_FIX_LO: d = s.fixed_blk[7:0];
      PBL_F_FIX_HI: d = {2'b00, s.fixed_blk[13:8]};
      default: d = 8'h00; // Unmapped addresses read zero
    endcase
    return d;
  endfunction

  // ==========================================================
  // Datapath terms
  logic take;
  logic push;
  logic pop;
  logic row_par;
  logic col_par;
  logic [1:0] phase_idx;
  logic [pbl_pkg::PIX_W-1:0] adc_black;
  logic signed [pbl_pkg::WIDE_W-1:0] offs_sum;
  logic [pbl_pkg::PIX_W-1:0] level;
  logic signed [pbl_pkg::WIDE_W-1:0] gained;
  logic [pbl_pkg::PIX_W-1:0] pix_out;

  // Pixel phase of the sample now on the input
  always_comb begin
    take = in_valid && s_r.in_ready;
    push = take && !in_dark;
    pop = s_r.out_valid && out_ready;
    if (in_sof) begin
      row_par = 1'b0;
    end else if (in_sol) begin
      row_par = ~s_r.row_odd;
    end else begin
      row_par = s_r.row_odd;
    end
    col_par = (in_sol || s_r.phase == pbl_pkg::PBL_PH_DARK) ?
              1'b0 : s_r.col_odd;
    phase_idx = {row_par, col_par};
  end

  // Offset then gain; gain last so offsets need no retune
  always_comb begin
    adc_black = s_r.clamp_dis ? s_r.fixed_blk : s_r.row_black;
    offs_sum = $signed(pbl_pkg::WIDE_W'(in_data))
             - $signed(pbl_pkg::WIDE_W'(adc_black))
             + $signed(pbl_pkg::WIDE_W'(s_r.target));
    level = clip_pix(offs_sum);
    gained = $signed(pbl_pkg::WIDE_W'(level)
             * pbl_pkg::WIDE_W'({1'b0, s_r.gain[phase_idx]} + 9'h001))
             >>> pbl_pkg::GAIN_FRAC;
    pix_out = clip_pix(gained);
  end

  // ==========================================================
  // Next state
  always_comb begin
    logic [pbl_pkg::PIX_W+3:0] sum_new;
    logic [4:0] cnt_new;
    s_nxt = s_r;
    sum_new = '0;
    cnt_new = '0;

    // Register writes; 14/16-bit fields take a byte per address
    // A read of the same field in that cycle still sees the old byte
    if (cfg_wr) begin
      case (field_sel(cfg_bank, cfg_addr))
        PBL_F_TYPE: s_nxt.sensor_type = cfg_wdata[0];
        PBL_F_GAIN_EE: s_nxt.gain[0] = cfg_wdata;
        PBL_F_GAIN_EO: s_nxt.gain[1] = cfg_wdata;
        PBL_F_GAIN_OE: s_nxt.gain[2] = cfg_wdata;
        PBL_F_GAIN_OO: s_nxt.gain[3] = cfg_wdata;
        PBL_F_TGT_LO: s_nxt.target[7:0] = cfg_wdata;
        PBL_F_TGT_HI: s_nxt.target[13:8] = cfg_wdata[5:0];
        PBL_F_ANA: s_nxt.ana_gain = cfg_wdata;
        PBL_F_FINE_LO: s_nxt.fine_off[7:0] = cfg_wdata;
        PBL_F_FINE_HI: s_nxt.fine_off[15:8] = cfg_wdata;
        PBL_F_CLAMP: s_nxt.clamp_dis = cfg_wdata[0];
        PBL_F_FIX_LO: s_nxt.fixed_blk[7:0] = cfg_wdata;
        PBL_F_FIX_HI: s_nxt.fixed_blk[13:8] = cfg_wdata[5:0];
        // Unmapped addresses in either bank change nothing
        default: s_nxt.rdata = s_r.rdata;
      endcase
    end

    // Read data held until next read
    if (cfg_rd) begin
      s_nxt.rdata = reg_read(field_sel(cfg_bank, cfg_addr), s_r);
    end

    // Row and column parity tracking
    if (take) begin
      s_nxt.row_odd = row_par;
      if (in_dark) begin
        if (in_sol) begin
          s_nxt.phase = pbl_pkg::PBL_PH_DARK;
        end
      end else begin
        s_nxt.phase = pbl_pkg::PBL_PH_ACTIVE;
        s_nxt.col_odd = ~col_par;
      end
    end

    // Per-row dark average; a short dark run keeps last level
    // Count stops at the window size, so a long dark run cannot wrap
    if (take && in_dark) begin
      case (s_r.phase)
        pbl_pkg::PBL_PH_DARK: begin
          sum_new = s_r.dark_sum + (pbl_pkg::PIX_W + 4)'(in_data);
          cnt_new = s_r.dark_cnt + 5'h01;
        end
        default: begin
          sum_new = s_r.dark_sum;
          cnt_new = s_r.dark_cnt;
        end
      endcase
      if (in_sol) begin
        sum_new = (pbl_pkg::PIX_W + 4)'(in_data);
        cnt_new = 5'h01;
      end
      if (s_r.phase == pbl_pkg::PBL_PH_DARK || in_sol) begin
        if (cnt_new <= DARK_N) begin
          s_nxt.dark_sum = sum_new;
          s_nxt.dark_cnt = cnt_new;
        end
        if (cnt_new == DARK_N) begin
          s_nxt.row_black =
            pbl_pkg::PIX_W'(sum_new >> DARK_LOG2);
        end
      end
    end

    // Two-entry output buffer; stall upstream when full
    // Ready is registered: it falls the cycle after the second fill
    if (pop) begin
      s_nxt.buf_q[0] = s_r.buf_q[1];
      s_nxt.cnt = s_r.cnt - 2'd1;
    end
    if (push) begin
      s_nxt.buf_q[s_nxt.cnt[0]] = pix_out;
      s_nxt.cnt = s_nxt.cnt + 2'd1;
    end
    s_nxt.out_valid = (s_nxt.cnt != 2'd0);
    s_nxt.in_ready = (s_nxt.cnt != 2'd2);
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
      s_r.sensor_type <= pbl_pkg::RST_SENSOR_TYPE;
      s_r.fine_off <= pbl_pkg::RST_FINE_OFF;
      s_r.clamp_dis <= pbl_pkg::RST_CLAMP_DIS;
      s_r.fixed_blk <= pbl_pkg::RST_FIXED;
      s_r.gain <= {4{pbl_pkg::RST_GAIN}};
      s_r.target <= pbl_pkg::RST_TARGET;
      s_r.ana_gain <= pbl_pkg::RST_ANA_GAIN;
      s_r.phase <= pbl_pkg::PBL_PH_DARK;
      s_r.in_ready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs straight from the state register
  assign cfg_rdata = s_r.rdata;
  assign in_ready = s_r.in_ready;
  assign out_valid = s_r.out_valid;
  assign out_data = s_r.buf_q[0];
  assign sensor_type = s_r.sensor_type;
  assign analog_gain_setting = s_r.ana_gain;
  assign fine_black_offset = s_r.fine_off;

endmodule

// ==== test/pbl_black_gain_checker.sv ====
`timescale 1ns/1ns
// ==========
// Port checker
module pbl_black_gain_checker (
  input wire logic core_clk, // Clock
  input wire logic arst_n, // Reset
  input wire logic cfg_wr, // Write
  input wire logic cfg_rd, // Read
  input wire logic cfg_bank, // Bank
  input wire logic [pbl_pkg::ADDR_W-1:0] cfg_addr, // Address
  input wire logic [7:0] cfg_wdata, // Write byte
  input wire logic [7:0] cfg_rdata, // Read byte
  input wire logic in_valid, // Sample valid
  input wire logic in_ready, // Room
  input wire logic in_dark, // Dark sample
  input wire logic out_valid, // Pixel valid
  input wire logic out_ready, // Taken
  input wire logic [pbl_pkg::PIX_W-1:0] out_data, // Pixel
  input wire logic sensor_type, // Type
  input wire logic [pbl_pkg::GAIN_W-1:0] analog_gain_setting, // Gain
  input wire logic [15:0] fine_black_offset // Offset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Two edges allowed for the register copies on the ports
  chk_rdata_hold: assert property (!cfg_rd |=> $stable(cfg_rdata))
    else $error("read byte moved without read");
  chk_out_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data)) else $error("pixel lost in stall");
  chk_pass_thru: assert property (in_valid && in_ready && !in_dark
    && !out_valid |=> out_valid) else $error("pixel not forwarded");
  chk_dark_drop: assert property (in_valid && in_ready && in_dark
    && !out_valid |=> !out_valid) else $error("dark pixel forwarded");
  chk_full_stays: assert property (out_valid && !out_ready &&
    !in_ready |=> !in_ready) else $error("room without pop");
  chk_type_write: assert property (cfg_wr && !cfg_bank &&
    cfg_addr == pbl_pkg::ADDR_SENSOR_TYPE |-> ##2
    sensor_type == $past(cfg_wdata[0], 2)) else $error("type wrong");
  chk_ana_write: assert property (cfg_wr && !cfg_bank &&
    cfg_addr == pbl_pkg::ADDR_ANA_GAIN |-> ##2
    analog_gain_setting == $past(cfg_wdata, 2)) else $error("gain wrong");
  chk_fine_write: assert property (cfg_wr && cfg_bank &&
    cfg_addr == pbl_pkg::ADDR_FINE_OFF_HI |-> ##2
    fine_black_offset[15:8] == $past(cfg_wdata, 2)) else $error("offset");
  chk_regs_quiet: assert property (!cfg_wr && !$past(cfg_wr) |=>
    $stable(fine_black_offset) && $stable(analog_gain_setting))
    else $error("register copy moved");
  cov_full: cover property (out_valid && !out_ready && !in_ready);
  cov_dark: cover property (in_valid && in_ready && in_dark);
  cov_read: cover property (cfg_rd);
endmodule
bind pbl_black_gain pbl_black_gain_checker i_chk (.core_clk, .arst_n,
  .cfg_wr, .cfg_rd, .cfg_bank, .cfg_addr, .cfg_wdata, .cfg_rdata,
  .in_valid, .in_ready, .in_dark, .out_valid, .out_ready, .out_data,
  .sensor_type, .analog_gain_setting, .fine_black_offset);

// ==== test/pbl_sink.sv ====
`timescale 1ns/1ns
// ==========
// Serializer model: prompt, every other cycle, or stalled
module pbl_sink (
  input wire logic core_clk, // Clock
  input wire logic arst_n, // Reset
  input wire logic [1:0] mode, // 0 prompt, 1 slow, 2 stall
  output logic out_ready // To block
);
  logic tgl;
  // Ready moves on the falling edge, clear of sampling
  always @(negedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tgl <= 1'b0;
      out_ready <= 1'b0;
    end else begin
      tgl <= !tgl;
      out_ready <= (mode == 2'h0) || (mode == 2'h1 && tgl);
    end
  end
endmodule

// ==== test/pbl_black_gain_tb.sv ====
`timescale 1ns/1ns
module pbl_black_gain_tb;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cfg_wr = 1'b0, cfg_rd = 1'b0, cfg_bank = 1'b0;
  logic [pbl_pkg::ADDR_W-1:0] cfg_addr = 7'h00;
  logic [7:0] cfg_wdata = 8'h00, cfg_rdata, ana;
  logic in_valid = 1'b0, in_sof = 1'b0, in_sol = 1'b0, in_dark = 1'b0;
  logic [13:0] in_data = 14'h0000, out_data;
  logic in_ready, out_valid, out_ready, sensor_type;
  logic [15:0] fine;
  logic [1:0] mode = 2'h0;
  logic [13:0] exp_q[$];
  int bad_count = 0, samples_checked = 0, blk = 0;
  int tgt = 128;
  always #4 core_clk = ~core_clk;
  pbl_black_gain #(.DARK_LOG2(2)) i_dut (.core_clk, .arst_n, .cfg_wr,
    .cfg_rd, .cfg_bank, .cfg_addr, .cfg_wdata, .cfg_rdata, .in_valid,
    .in_ready, .in_data, .in_sof, .in_sol, .in_dark, .out_valid,
    .out_ready, .out_data, .sensor_type, .analog_gain_setting(ana),
    .fine_black_offset(fine));
  pbl_sink i_sink (.core_clk, .arst_n, .mode, .out_ready);
  // ==========
  // Helpers
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic b, input logic [6:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {cfg_wr, cfg_bank, cfg_addr, cfg_wdata} = {1'b1, b, a, d};
    @(negedge core_clk);
    cfg_wr = 1'b0;
  endtask
  task automatic rd(input logic b, input logic [6:0] a, input logic [7:0] e);
    @(negedge core_clk);
    {cfg_rd, cfg_bank, cfg_addr} = {1'b1, b, a};
    @(negedge core_clk);
    cfg_rd = 1'b0;
    @(negedge core_clk);
    cmp(16'(cfg_rdata), 16'(e));
  endtask
  // Expected pixel: offset mapping clipped, then gain clipped
  function automatic logic [13:0] ex(input int d, input int g);
    int t;
    t = d - blk + tgt;
    t = t < 0 ? 0 : (t > 16383 ? 16383 : t);
    t = (t * (g + 1)) >> 4;
    return t > 16383 ? 14'h3FFF : t[13:0];
  endfunction
  // Valid stays up on return so that pixels can follow back to back
  task automatic px(input int d, input logic s, l, k, input int g);
    int n;
    @(negedge core_clk);
    {in_valid, in_data, in_sof, in_sol, in_dark} = {1'b1, d[13:0], s, l, k};
    if (!k) exp_q.push_back(ex(d, g));
    // Ready is judged at the falling edge, where it has settled
    n = 0;
    while (in_ready !== 1'b1 && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 50) begin
      cmp(16'h0, 16'h1);
      results();
    end else begin
      @(posedge core_clk);
    end
  endtask
  task automatic drain;
    int n;
    @(negedge core_clk);
    in_valid = 1'b0;
    for (n = 0; n < 200 && exp_q.size() > 0; n++) @(negedge core_clk);
    if (n == 200) begin
      cmp(16'h0, 16'h1);
      results();
    end
  endtask
  // Every pixel taken by the serializer is held against the queue
  always @(posedge core_clk) begin
    if (arst_n && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0) cmp(16'h0, 16'h1);
      else cmp(16'(out_data), 16'(exp_q.pop_front()));
    end
  end
  // ==========
  // Scenarios
  task automatic t_regs;
    rd(0, pbl_pkg::ADDR_SENSOR_TYPE, 8'h00);
    for (int i = 0; i < 4; i++) rd(0, pbl_pkg::ADDR_GAIN_EE + 7'(i), 8'h0F);
    rd(0, pbl_pkg::ADDR_TARGET_LO, 8'h80);
    wr(0, pbl_pkg::ADDR_TARGET_HI, 8'hFF);
    rd(0, pbl_pkg::ADDR_TARGET_HI, 8'h3F);
    wr(0, pbl_pkg::ADDR_TARGET_HI, 8'h00);
    wr(1, pbl_pkg::ADDR_FIXED_HI, 8'hFF);
    rd(1, pbl_pkg::ADDR_FIXED_HI, 8'h3F);
    rd(0, 7'h10, 8'h00);
    wr(0, pbl_pkg::ADDR_SENSOR_TYPE, 8'h01);
    wr(0, pbl_pkg::ADDR_ANA_GAIN, 8'hA5);
    wr(1, pbl_pkg::ADDR_FINE_OFF_HI, 8'h5A);
    repeat (2) @(negedge core_clk);
    cmp(16'(sensor_type), 16'h1);
    cmp(16'(ana), 16'h00A5);
    cmp(fine, 16'h5A00);
    rd(1, pbl_pkg::ADDR_FINE_OFF_HI, 8'h5A);
    rd(0, pbl_pkg::ADDR_ANA_GAIN, 8'hA5);
    rd(0, pbl_pkg::ADDR_FIXED_HI, 8'h00);
  endtask
  task automatic t_fixed;
    blk = 300;
    wr(1, pbl_pkg::ADDR_CLAMP_DIS, 8'h01);
    rd(1, pbl_pkg::ADDR_CLAMP_DIS, 8'h01);
    wr(1, pbl_pkg::ADDR_FIXED_LO, 8'h2C);
    wr(1, pbl_pkg::ADDR_FIXED_HI, 8'h01);
    wr(0, pbl_pkg::ADDR_GAIN_EE, 8'h0F);
    wr(0, pbl_pkg::ADDR_GAIN_EO, 8'h1F);
    wr(0, pbl_pkg::ADDR_GAIN_OE, 8'h07);
    wr(0, pbl_pkg::ADDR_GAIN_OO, 8'hFF);
    px(1000, 1, 1, 0, 15);
    px(50, 0, 0, 0, 31);
    px(50, 0, 1, 0, 7);
    px(16000, 0, 0, 0, 255);
    drain();
  endtask
  task automatic t_auto;
    wr(1, pbl_pkg::ADDR_CLAMP_DIS, 8'h00);
    px(196, 1, 1, 1, 0);
    px(198, 0, 0, 1, 0);
    px(202, 0, 0, 1, 0);
    px(204, 0, 0, 1, 0);
    blk = 200;
    px(1000, 0, 0, 0, 15);
    drain();
    wr(0, pbl_pkg::ADDR_GAIN_EO, 8'h3F);
    px(1000, 0, 0, 0, 63);
    drain();
  endtask
  task automatic t_stall;
    mode = 2'h2;
    px(100, 0, 1, 0, 7);
    px(101, 0, 0, 0, 255);
    @(negedge core_clk);
    in_valid = 1'b0;
    repeat (2) @(negedge core_clk);
    cmp(16'(in_ready), 16'h0);
    mode = 2'h1;
    for (int i = 0; i < 6; i++) px(300 + i, 0, i == 0, 0, i % 2 ? 63 : 15);
    drain();
  endtask
  initial begin
    repeat (10) @(negedge core_clk);
    arst_n = 1'b1;
    t_regs();
    t_fixed();
    t_auto();
    t_stall();
    results();
  end
endmodule
